// ===== src/cll_pkg.sv
/*
 * Constants and types shared by the comparator logic and latch block:
 * register indices, field positions, reset values, bus codes.
 * Assumes a 32-bit AXI4-Lite slave with 12-bit byte addresses.
 */
package cll_pkg;

    // register indices; the byte address is four times the index
    localparam logic [9:0] IDX_READ_CLEAR  = 10'h078;
    localparam logic [9:0] IDX_INPUT_SEL   = 10'h079;
    localparam logic [9:0] IDX_ENABLE_CTRL = 10'h07A;
    localparam logic [9:0] IDX_OUTPUT_CTRL = 10'h07B;
    localparam logic [9:0] IDX_FUNC_SEL    = 10'h07C;

    localparam logic [7:0] RST_READ_CLEAR  = 8'h00;
    localparam logic [7:0] RST_INPUT_SEL   = 8'h00;
    localparam logic [7:0] RST_ENABLE_CTRL = 8'h00;
    localparam logic [7:0] RST_OUTPUT_CTRL = 8'h00;
    localparam logic [7:0] RST_FUNC_SEL    = 8'h00;

    // channel n field = channel 0 position + n * CH_STEP; latch and live bits of channel n sit at position + n
    localparam int CH_STEP        = 4;
    localparam int EN_POS         = 0;
    localparam int MAIN_SEL_POS   = 0;
    localparam int CLR_SRC_POS    = 1;
    localparam int PIN_SEL_POS    = 2;
    localparam int ANALOG_POS     = 3;
    localparam int FUNC_POS       = 0;
    localparam int FUNC_W         = 4;
    localparam int LATCH_POS      = 0;
    localparam int LIVE_POS       = 4;
    localparam int CH0_NEG_POS    = 0;
    localparam int CH0_POS_POS    = 2;
    localparam int CH1_NEG_POS    = 4;
    localparam int CH1_POS_POS    = 6;
    localparam int SRC_W          = 2;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0]
    {
        ST_IDLE = 2'h1,
        ST_BUSY = 2'h2
    } cll_bus_e;

endpackage

// ===== src/cll_channel.sv
/*
 * One comparator channel: registered two-input function and a
 * set/clear latch.
 * Assumes the comparator level is synchronous to the clock.
 */
module cll_channel
    import cll_pkg::*;
(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              reset_n,
    // inputs of the function
    input  wire logic              own_in,
    input  wire logic              nbr_in,
    input  wire logic [FUNC_W-1:0] func_code,
    // clear control
    input  wire logic              clr_src_edge,
    input  wire logic              clr_by_write,
    input  wire logic              other_rise,
    // results
    output logic                   lut_reg,
    output logic                   latch_reg,
    output logic                   lut_rise
);

    logic       lut_prev_reg;
    logic       lut_next;
    logic       clear;
    logic [1:0] sel;

    // code is a truth table, bit 3 for A=0,B=0 down to bit 0 for A=1,B=1
    always_comb
    begin
        sel      = {own_in, nbr_in};
        lut_next = func_code[2'h3 - sel];
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            lut_reg      <= 1'b0;
            lut_prev_reg <= 1'b0;
        end
        else
        begin
            lut_reg      <= lut_next;
            lut_prev_reg <= lut_reg;
        end
    end

    assign lut_rise = lut_reg & ~lut_prev_reg;

    // clear source picked per channel
    assign clear = clr_src_edge ? other_rise : clr_by_write;

    // set beats clear so a high function output is never lost
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            latch_reg <= 1'b0;
        else
            latch_reg <= lut_reg | (latch_reg & ~clear);
    end

endmodule

// ===== src/cll_top.sv
/*
 * Comparator logic and latch block: two channels of programmable
 * two-input function and latch, output routing and an AXI4-Lite
 * register slave.
 * Assumes comparator levels synchronous to CLK and a single clock.
 */
module cll_top
    import cll_pkg::*;
(
    // clock and reset
    input  wire logic        CLK,
    input  wire logic        RESET_N,
    // axi4-lite write address
    input  wire logic [11:0] S_AXI_AWADDR,
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    // axi4-lite write data
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    // axi4-lite write response
    output logic [1:0]       S_AXI_BRESP,
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    // axi4-lite read address
    input  wire logic [11:0] S_AXI_ARADDR,
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    // axi4-lite read data
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY,
    // comparators
    input  wire logic [1:0]  CMP_IN,
    output logic [1:0]       COMP_ON,
    output logic [1:0]       CH0_POS_SOURCE,
    output logic [1:0]       CH0_NEG_SOURCE,
    output logic [1:0]       CH1_POS_SOURCE,
    output logic [1:0]       CH1_NEG_SOURCE,
    // routed results
    output logic [1:0]       MAIN_OUT,
    output logic [1:0]       PIN_OUT,
    output logic [1:0]       ANALOG_OUT_CONNECT
);

    // registers
    logic [7:0]  input_select_reg;
    logic [7:0]  enable_control_reg;
    logic [7:0]  output_control_reg;
    logic [7:0]  function_select_reg;

    // write channel
    cll_bus_e    wr_state_reg;
    logic        aw_held_reg;
    logic        w_held_reg;
    logic [9:0]  wr_idx_reg;
    logic [7:0]  wr_data_reg;
    logic        wr_strb_reg;
    logic        do_write;
    logic        wr_mapped;
    logic        wr_lane;
    logic [1:0]  bresp_reg;

    // read channel
    cll_bus_e    rd_state_reg;
    logic [31:0] rdata_reg;
    logic [1:0]  rresp_reg;
    logic [9:0]  rd_idx;
    logic [7:0]  rd_byte;
    logic        rd_mapped;

    // channel signals
    logic [1:0]  cmp_gated;
    logic [1:0]  lut_q;
    logic [1:0]  latch_q;
    logic [1:0]  lut_rise;
    logic [1:0]  clr_by_write;
    logic [7:0]  read_clear_view;

    // comparators of disabled channels read as low
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++)
        begin : g_ch
            assign cmp_gated[ch] = CMP_IN[ch]
                & enable_control_reg[EN_POS + ch * CH_STEP];

            // write clearing only acts when that clear source is chosen
            assign clr_by_write[ch] = do_write & wr_lane
                & (wr_idx_reg == IDX_READ_CLEAR)
                & ~wr_data_reg[LATCH_POS + ch]
                & ~output_control_reg[CLR_SRC_POS + ch * CH_STEP];

            cll_channel u_channel
            (
                .clk          (CLK),
                .reset_n      (RESET_N),
                .own_in       (cmp_gated[ch]),
                .nbr_in       (cmp_gated[1 - ch]),
                .func_code    (function_select_reg[FUNC_POS + ch * CH_STEP +: FUNC_W]),
                .clr_src_edge (output_control_reg[CLR_SRC_POS + ch * CH_STEP]),
                .clr_by_write (clr_by_write[ch]),
                .other_rise   (lut_rise[1 - ch]),
                .lut_reg      (lut_q[ch]),
                .latch_reg    (latch_q[ch]),
                .lut_rise     (lut_rise[ch])
            );

            always_ff @(posedge CLK or negedge RESET_N)
            begin
                if (!RESET_N)
                begin
                    MAIN_OUT[ch]           <= 1'b0;
                    PIN_OUT[ch]            <= 1'b0;
                    ANALOG_OUT_CONNECT[ch] <= 1'b0;
                    COMP_ON[ch]            <= 1'b0;
                end
                else
                begin
                    MAIN_OUT[ch] <= output_control_reg[MAIN_SEL_POS + ch * CH_STEP]
                        ? latch_q[ch] : lut_q[ch];
                    PIN_OUT[ch] <= output_control_reg[PIN_SEL_POS + ch * CH_STEP]
                        ? latch_q[ch] : lut_q[ch];
                    ANALOG_OUT_CONNECT[ch] <=
                        output_control_reg[ANALOG_POS + ch * CH_STEP];
                    COMP_ON[ch] <= enable_control_reg[EN_POS + ch * CH_STEP];
                end
            end
        end
    endgenerate

    // source selects go straight out of the register
    assign CH0_NEG_SOURCE = input_select_reg[CH0_NEG_POS +: SRC_W];
    assign CH0_POS_SOURCE = input_select_reg[CH0_POS_POS +: SRC_W];
    assign CH1_NEG_SOURCE = input_select_reg[CH1_NEG_POS +: SRC_W];
    assign CH1_POS_SOURCE = input_select_reg[CH1_POS_POS +: SRC_W];

    // write path: address and data may arrive in either order
    assign S_AXI_AWREADY = ~aw_held_reg & (wr_state_reg == ST_IDLE);
    assign S_AXI_WREADY  = ~w_held_reg & (wr_state_reg == ST_IDLE);
    assign do_write      = aw_held_reg & w_held_reg & (wr_state_reg == ST_IDLE);
    assign wr_lane       = wr_strb_reg;

    always_comb
    begin
        case (wr_idx_reg)
            IDX_READ_CLEAR,
            IDX_INPUT_SEL,
            IDX_ENABLE_CTRL,
            IDX_OUTPUT_CTRL,
            IDX_FUNC_SEL: wr_mapped = 1'b1;
            default:      wr_mapped = 1'b0;
        endcase
    end

    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            aw_held_reg <= 1'b0;
            wr_idx_reg  <= 10'h000;
        end
        else if (S_AXI_AWVALID && S_AXI_AWREADY)
        begin
            aw_held_reg <= 1'b1;
            wr_idx_reg  <= S_AXI_AWADDR[11:2];
        end
        else if (do_write)
            aw_held_reg <= 1'b0;
    end

    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            w_held_reg  <= 1'b0;
            wr_data_reg <= 8'h00;
            wr_strb_reg <= 1'b0;
        end
        else if (S_AXI_WVALID && S_AXI_WREADY)
        begin
            w_held_reg  <= 1'b1;
            wr_data_reg <= S_AXI_WDATA[7:0];
            wr_strb_reg <= S_AXI_WSTRB[0];
        end
        else if (do_write)
            w_held_reg <= 1'b0;
    end

    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            wr_state_reg <= ST_IDLE;
            bresp_reg    <= RESP_OKAY;
        end
        else
        begin
            case (wr_state_reg)
                ST_IDLE:
                begin
                    if (do_write)
                    begin
                        wr_state_reg <= ST_BUSY;
                        bresp_reg    <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
                    end
                end
                ST_BUSY:
                begin
                    if (S_AXI_BREADY)
                        wr_state_reg <= ST_IDLE;
                end
                default: wr_state_reg <= ST_IDLE;
            endcase
        end
    end

    assign S_AXI_BVALID = (wr_state_reg == ST_BUSY);
    assign S_AXI_BRESP  = bresp_reg;

    // only byte lane 0 carries register data; upper lanes are ignored
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            input_select_reg    <= RST_INPUT_SEL;
            enable_control_reg  <= RST_ENABLE_CTRL;
            output_control_reg  <= RST_OUTPUT_CTRL;
            function_select_reg <= RST_FUNC_SEL;
        end
        else if (do_write && wr_lane)
        begin
            case (wr_idx_reg)
                IDX_INPUT_SEL:   input_select_reg    <= wr_data_reg;
                IDX_OUTPUT_CTRL: output_control_reg  <= wr_data_reg;
                IDX_FUNC_SEL:    function_select_reg <= wr_data_reg;
                // reserved enable bits are kept at zero
                IDX_ENABLE_CTRL:
                begin
                    enable_control_reg <= 8'h00;
                    enable_control_reg[EN_POS] <= wr_data_reg[EN_POS];
                    enable_control_reg[EN_POS + CH_STEP] <=
                        wr_data_reg[EN_POS + CH_STEP];
                end
                default:
                begin
                end
            endcase
        end
    end

    // read path: one read at a time, data one cycle after the address
    assign rd_idx        = S_AXI_ARADDR[11:2];
    assign S_AXI_ARREADY = (rd_state_reg == ST_IDLE);

    always_comb
    begin
        read_clear_view = RST_READ_CLEAR;
        read_clear_view[LIVE_POS +: 2]  = cmp_gated;
        read_clear_view[LATCH_POS +: 2] = latch_q;
    end

    always_comb
    begin
        rd_mapped = 1'b1;
        case (rd_idx)
            IDX_READ_CLEAR:  rd_byte = read_clear_view;
            IDX_INPUT_SEL:   rd_byte = input_select_reg;
            IDX_ENABLE_CTRL: rd_byte = enable_control_reg;
            IDX_OUTPUT_CTRL: rd_byte = output_control_reg;
            IDX_FUNC_SEL:    rd_byte = function_select_reg;
            default:
            begin
                rd_byte   = 8'h00;
                rd_mapped = 1'b0;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            rd_state_reg <= ST_IDLE;
            rdata_reg    <= 32'h00000000;
            rresp_reg    <= RESP_OKAY;
        end
        else
        begin
            case (rd_state_reg)
                ST_IDLE:
                begin
                    if (S_AXI_ARVALID)
                    begin
                        rd_state_reg <= ST_BUSY;
                        rdata_reg    <= {24'h000000, rd_byte};
                        rresp_reg    <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
                    end
                end
                ST_BUSY:
                begin
                    if (S_AXI_RREADY)
                        rd_state_reg <= ST_IDLE;
                end
                default: rd_state_reg <= ST_IDLE;
            endcase
        end
    end

    assign S_AXI_RVALID = (rd_state_reg == ST_BUSY);
    assign S_AXI_RDATA  = rdata_reg;
    assign S_AXI_RRESP  = rresp_reg;

endmodule

// ===== dv/cll_chk.sv
/*
 * Checker for cll_top: bus handshakes and channel output relations.
 * Assumes bench writes offer address and data in the same cycle.
 */
module cll_chk
    import cll_pkg::*;
(
    // clock and reset
    input wire logic        CLK,
    input wire logic        RESET_N,
    // register bus
    input wire logic [11:0] S_AXI_AWADDR,
    input wire logic        S_AXI_AWVALID,
    input wire logic        S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0]  S_AXI_WSTRB,
    input wire logic        S_AXI_WVALID,
    input wire logic        S_AXI_WREADY,
    input wire logic        S_AXI_BVALID,
    input wire logic        S_AXI_BREADY,
    input wire logic        S_AXI_ARVALID,
    input wire logic        S_AXI_ARREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic        S_AXI_RVALID,
    input wire logic        S_AXI_RREADY,
    // channels
    input wire logic [1:0]  CMP_IN,
    input wire logic [1:0]  COMP_ON,
    input wire logic [1:0]  MAIN_OUT,
    input wire logic [1:0]  PIN_OUT,
    input wire logic [1:0]  ANALOG_OUT_CONNECT
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [7:0] en_reg;
    logic [7:0] oc_reg;
    logic [7:0] fc_reg;
    logic [2:0] age_reg;
    logic [1:0] g;
    logic       wr;

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RESET_N);

    assign wr = S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
    assign g  = CMP_IN & {en_reg[4], en_reg[0]};

    function automatic logic lut(input logic [3:0] c, input logic a, input logic b);
        return c[~{a, b}];
    endfunction

    // shadows miss split writes; bench never splits them
    always_ff @(posedge CLK or negedge RESET_N)
        if (!RESET_N)
        begin
            en_reg <= 8'h00;
            oc_reg <= 8'h00;
            fc_reg <= 8'h00;
        end
        else if (wr && S_AXI_WSTRB[0])
            case (S_AXI_AWADDR[11:2])
                IDX_ENABLE_CTRL: en_reg <= S_AXI_WDATA[7:0];
                IDX_OUTPUT_CTRL: oc_reg <= S_AXI_WDATA[7:0];
                IDX_FUNC_SEL:    fc_reg <= S_AXI_WDATA[7:0];
                default:         en_reg <= en_reg;
            endcase

    // cycles since the last write, so relations wait out the update latency
    always_ff @(posedge CLK or negedge RESET_N)
        if (!RESET_N)
            age_reg <= 3'h0;
        else if (wr)
            age_reg <= 3'h0;
        else if (age_reg != 3'h7)
            age_reg <= age_reg + 3'h1;

    chk_write_resp: assert property (wr |=> !S_AXI_AWREADY ##1 S_AXI_BVALID)
        else $error("write response not on time");
    chk_b_done: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID && S_AXI_AWREADY)
        else $error("write response not retired");
    chk_read_lat: assert property (S_AXI_ARVALID && S_AXI_ARREADY
        |=> S_AXI_RVALID && S_AXI_RDATA[31:8] == 24'h0)
        else $error("read data late or upper bits set");
    chk_r_done: assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID && S_AXI_ARREADY)
        else $error("read data not retired");
    chk_enable_copy: assert property (age_reg >= 3
        |-> COMP_ON == {en_reg[4], en_reg[0]})
        else $error("enable outputs differ from register");
    chk_analog_copy: assert property (age_reg >= 3
        |-> ANALOG_OUT_CONNECT == {oc_reg[7], oc_reg[3]})
        else $error("analog connect differs from register");
    chk_main_func: assert property (age_reg >= 5 && !oc_reg[0]
        |-> MAIN_OUT[0] == lut(fc_reg[3:0], $past(g[0], 2), $past(g[1], 2)))
        else $error("channel 0 function output wrong");
    chk_pin_func: assert property (age_reg >= 5 && !oc_reg[6]
        |-> PIN_OUT[1] == lut(fc_reg[7:4], $past(g[1], 2), $past(g[0], 2)))
        else $error("channel 1 pin output wrong");
    chk_latch_set: assert property (age_reg >= 5 && oc_reg[0]
        && lut(fc_reg[3:0], $past(g[0], 3), $past(g[1], 3)) |-> MAIN_OUT[0])
        else $error("channel 0 latch not set");
    chk_latch_hold: assert property (age_reg >= 5 && oc_reg[0] && !oc_reg[1]
        && MAIN_OUT[0] |=> MAIN_OUT[0])
        else $error("channel 0 latch dropped without a write");
endmodule

// ===== dv/cll_cmp_model.sv
/*
 * Model of the two comparators at the block's far side.
 * Assumes the bench sets the wanted levels just after a clock edge.
 */
module cll_cmp_model
(
    // clock
    input  wire logic       clk,
    // wanted levels and power from the block
    input  wire logic [1:0] want,
    input  wire logic [1:0] on,
    // comparator results
    output logic [1:0]      cmp
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [1:0] junk = 2'h1;

    // an unpowered comparator gives no trustworthy level
    always @(posedge clk)
        junk <= ~junk;

    assign cmp = (want & on) | (junk & ~on);
endmodule

// ===== dv/cll_top_tb.sv
/*
 * Self-checking bench for cll_top: registers, function codes, enable
 * gating and both latch clear modes.
 * Assumes cll_chk and cll_cmp_model are compiled before it.
 */
module cll_top_tb
    import cll_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    localparam logic [11:0] A_RC = {IDX_READ_CLEAR, 2'h0};
    localparam logic [11:0] A_IS = {IDX_INPUT_SEL, 2'h0};
    localparam logic [11:0] A_EN = {IDX_ENABLE_CTRL, 2'h0};
    localparam logic [11:0] A_OC = {IDX_OUTPUT_CTRL, 2'h0};
    localparam logic [11:0] A_FS = {IDX_FUNC_SEL, 2'h0};

    logic        clk = 1'b0, rst_n = 1'b0;
    logic        aw_valid = 1'b0, w_valid = 1'b0, b_ready = 1'b0, ar_valid = 1'b0;
    logic        r_ready = 1'b0, awready, wready, bvalid, arready, rvalid;
    logic [11:0] aw_addr = 12'h000, ar_addr = 12'h000;
    logic [31:0] w_data = 32'h0, rdata;
    logic [3:0]  w_strb = 4'h1;
    logic [1:0]  want = 2'h0, bresp, rresp, cmp_in, comp_on, main_out, pin_out, ana;
    logic [1:0]  p1, n1, p0, n0;
    int          n_errors = 0, checks_done = 0;

    always #50 clk = ~clk;

    cll_cmp_model u_cmp (.clk(clk), .want(want), .on(comp_on), .cmp(cmp_in));

    cll_top uut (.CLK(clk), .RESET_N(rst_n),
        .S_AXI_AWADDR(aw_addr), .S_AXI_AWVALID(aw_valid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(w_data), .S_AXI_WSTRB(w_strb), .S_AXI_WVALID(w_valid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
        .S_AXI_BREADY(b_ready), .S_AXI_ARADDR(ar_addr), .S_AXI_ARVALID(ar_valid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(r_ready), .CMP_IN(cmp_in), .COMP_ON(comp_on),
        .CH0_POS_SOURCE(p0), .CH0_NEG_SOURCE(n0), .CH1_POS_SOURCE(p1),
        .CH1_NEG_SOURCE(n1), .MAIN_OUT(main_out), .PIN_OUT(pin_out),
        .ANALOG_OUT_CONNECT(ana));

    task automatic report_and_stop();
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        check(32'(got), 32'(exp));
    endtask

    task automatic tmo(input int n);
        if (n >= 50)
        begin
            n_errors++;
            report_and_stop();
        end
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
        int n;
        n = 0;
        aw_addr <= a;
        w_data <= {24'h0, d};
        aw_valid <= 1'b1;
        w_valid <= 1'b1;
        b_ready <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
            if (awready)
                aw_valid <= 1'b0;
            if (wready)
                w_valid <= 1'b0;
        end while (!bvalid && n < 50);
        b_ready <= 1'b0;
        tmo(n);
        chk_resp(bresp, r);
        // idle edge, so a following call never re-raises bready in this step
        @(posedge clk);
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
        int n;
        n = 0;
        ar_addr <= a;
        ar_valid <= 1'b1;
        r_ready <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
            if (arready)
                ar_valid <= 1'b0;
        end while (!rvalid && n < 50);
        r_ready <= 1'b0;
        tmo(n);
        check(rdata, {24'h0, d});
        chk_resp(rresp, r);
        // idle edge, so a following call never re-raises rready in this step
        @(posedge clk);
    endtask

    task automatic pulse(input logic [1:0] p);
        want <= p;
        tick(1);
        want <= 2'h0;
        tick(4);
    endtask

    task automatic t_reset();
        logic [11:0] a [5];
        a = '{A_RC, A_IS, A_EN, A_OC, A_FS};
        check(32'({comp_on, main_out, pin_out, ana, p1, n1, p0, n0}), 32'h0);
        foreach (a[i])
            rd(a[i], 8'h00, RESP_OKAY);
        rd(12'h000, 8'h00, RESP_SLVERR);
        wr(12'h1F4, 8'h5A, RESP_SLVERR);
        rd(12'h1F4, 8'h00, RESP_SLVERR);
    endtask

    task automatic t_config();
        wr(A_IS, 8'hE4, RESP_OKAY);
        check(32'({p1, n1, p0, n0}), 32'hE4);
        w_strb <= 4'h0;
        wr(A_IS, 8'h1B, RESP_OKAY);
        w_strb <= 4'h1;
        rd(A_IS, 8'hE4, RESP_OKAY);
        wr(A_EN, 8'h10, RESP_OKAY);
        rd(A_EN, 8'h10, RESP_OKAY);
        check(32'(comp_on), 32'h2);
        wr(A_OC, 8'h88, RESP_OKAY);
        rd(A_OC, 8'h88, RESP_OKAY);
        check(32'(ana), 32'h3);
        wr(A_OC, 8'h08, RESP_OKAY);
        rd(A_OC, 8'h08, RESP_OKAY);
        check(32'(ana), 32'h1);
    endtask

    task automatic t_func();
        logic [3:0] codes [8];
        logic [3:0] c;
        logic       e0;
        logic       e1;
        codes = '{4'h0, 4'h3, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hC};
        wr(A_EN, 8'h11, RESP_OKAY);
        wr(A_OC, 8'h00, RESP_OKAY);
        foreach (codes[i])
        begin
            c = codes[i];
            wr(A_FS, {c, c}, RESP_OKAY);
            rd(A_FS, {c, c}, RESP_OKAY);
            for (int k = 0; k < 4; k++)
            begin
                want <= 2'(k);
                tick(4);
                // own comparator is A, so the two channels swap operands
                e0 = c[~{k[0], k[1]}];
                e1 = c[~{k[1], k[0]}];
                check(32'({pin_out, main_out}), 32'({e1, e0, e1, e0}));
            end
        end
    endtask

    task automatic t_enable();
        wr(A_EN, 8'h01, RESP_OKAY);
        wr(A_FS, 8'h35, RESP_OKAY);
        want <= 2'h3;
        tick(4);
        wr(A_RC, 8'h00, RESP_OKAY);
        check(32'(main_out), 32'h0);
        rd(A_RC, 8'h10, RESP_OKAY);
        wr(A_RC, 8'h30, RESP_OKAY);
        rd(A_RC, 8'h10, RESP_OKAY);
    endtask

    task automatic t_wclear();
        want <= 2'h0;
        wr(A_EN, 8'h11, RESP_OKAY);
        wr(A_FS, 8'h33, RESP_OKAY);
        wr(A_OC, 8'h55, RESP_OKAY);
        wr(A_RC, 8'h00, RESP_OKAY);
        pulse(2'h1);
        check(32'({pin_out, main_out}), 32'h5);
        rd(A_RC, 8'h01, RESP_OKAY);
        pulse(2'h2);
        rd(A_RC, 8'h03, RESP_OKAY);
        wr(A_RC, 8'h01, RESP_OKAY);
        tick(4);
        check(32'(main_out), 32'h1);
        wr(A_RC, 8'h00, RESP_OKAY);
        tick(4);
        check(32'({pin_out, main_out}), 32'h0);
    endtask

    task automatic t_eclear();
        wr(A_OC, 8'h33, RESP_OKAY);
        pulse(2'h1);
        wr(A_RC, 8'h00, RESP_OKAY);
        tick(4);
        check(32'(main_out), 32'h1);
        want <= 2'h2;
        tick(4);
        check(32'(main_out), 32'h2);
        want <= 2'h0;
        tick(2);
        want <= 2'h1;
        tick(4);
        check(32'(main_out), 32'h1);
        want <= 2'h0;
    endtask

    initial
    begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset();
        t_config();
        t_func();
        t_enable();
        t_wclear();
        t_eclear();
        report_and_stop();
    end
endmodule

bind cll_top cll_chk u_chk (.*);
